// ===== src/luc_baud.v
// Baud prescaler: makes a one-cycle sample tick every (divisor+1) clocks.
// Assumes the divisor may change at any time; the count restarts on clear.
`timescale 1ns/10ps
module luc_baud (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Control
	input wire clear_i,
	input wire [11:0] div_i,
	// Tick
	output reg tick_o
);
	reg [11:0] cnt_r;

	always @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			cnt_r <= 12'h000;
			tick_o <= 1'b0;
		end else if (cnt_r >= div_i) begin
			cnt_r <= 12'h000;
			tick_o <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 12'h001;
			tick_o <= 1'b0;
		end
	end
endmodule

// ===== src/luc_consts.vh
// Constants for the combined LIN/UART controller: register offsets, field positions, resets.
// Assumes a Wishbone byte-wide register bus with word-aligned registers.
`ifndef LUC_CONSTS_VH
`define LUC_CONSTS_VH

// Register byte offsets.
`define LUC_OFS_CONTROL 6'h00
`define LUC_OFS_STATUS 6'h04
`define LUC_OFS_IRQ_EN 6'h08
`define LUC_OFS_ERRORS 6'h0c
`define LUC_OFS_BIT_SAMPLING 6'h10
`define LUC_OFS_DIV_LOW 6'h14
`define LUC_OFS_DIV_HIGH 6'h18
`define LUC_OFS_LENGTHS 6'h1c
`define LUC_OFS_IDENT 6'h20
`define LUC_OFS_BUF_SEL 6'h24
`define LUC_OFS_DATA 6'h28

// Reset values.
`define LUC_RST_CONTROL 8'h00
`define LUC_RST_BIT_SAMPLING 8'h20
`define LUC_RST_IDENT 8'h80
`define LUC_SAMPLES_DEFAULT 6'h20

// Control register fields.
`define LUC_CTL_CMD_LO 0
`define LUC_CTL_CMD_GRP 2
`define LUC_CTL_ENABLE 3
`define LUC_CTL_CONF_LO 4
`define LUC_CTL_PROTO 6
`define LUC_CTL_SWRES 7
// Mask of control bits writable while busy: command, enable, soft reset.
`define LUC_CTL_BUSY_MASK 8'h8f

// Status register fields.
`define LUC_ST_RXOK 0
`define LUC_ST_TXOK 1
`define LUC_ST_ERR 3
`define LUC_ST_BUSY 4

// Error register fields.
`define LUC_ER_FRAME 4
`define LUC_ER_OVERRUN 6

// Frame configuration codes.
`define LUC_CONF_NONE 2'h0
`define LUC_CONF_EVEN 2'h1
`define LUC_CONF_ODD 2'h2
`define LUC_CONF_LISTEN 2'h3

// LIN header timing.
`define LUC_BREAK_MIN_BITS 5'h0b
`define LUC_BREAK_MAX_BITS 5'h1c
`define LUC_SYNC_EDGES 3'h4
`define LUC_MASTER_BIT 7

`endif

// ===== src/luc_top.v
// LIN/UART controller core: Wishbone register slave, UART byte services, LIN header resync.
// Assumes one clock clk_i and an asynchronous serial input that is synchronised here.
//
// What this block does
// - Low command bits choose UART service set.
// - UART mode bypasses FIFO; data single register.
// - Received char sets flag; read clears it.
// - Two-stage receive; overwrite flags overrun, framing.
// - Data write starts transmit, clears done flag.
// - Core reset full; soft reset partial only.
// - Soft reset keeps divisors, clears low nibbles.
// - Only the one I/O clock.
// - Protocol bit is stored only; no checksum logic uses it.
// - In LIN mode the configuration field only selects listening.
// - UART config picks parity or listening.
// - Listening loops tx to rx, disables pin.
// - Busy status bit mirrors internal busy.
// - LIN busy locks listed register writes; busy is never set in LIN mode, so no write is locked.
// - Abort deferred; disable and reset immediate.
// - Other command while busy: overrun, ignored.
// - UART busy only transmitting; locks control, data.
// - Bit rate: clock over samples times divisor plus one.
// - Receiver majority votes three samples.
// - Header: break 11..28 bits, sync retunes.
// - Tuned samples kept until response ends.
// - No resync when node is LIN master.
// - Clearing enable disables immediately.
// - Writing summary error bit clears errors.
`timescale 1ns/10ps
`include "luc_consts.vh"
module luc_top (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Serial pins
	input wire serial_rx_pin_i,
	output reg serial_tx_pin_o,
	output reg serial_tx_oe_n_o
);
	// ****************************************
	// Registers
	// ****************************************
	reg [7:0] ctl_r;
	reg rxok_r;
	reg txok_r;
	reg [7:0] irq_en_r;
	reg [7:0] err_r;
	reg [7:0] btr_r;
	reg [7:0] div_lo_r;
	reg [7:0] div_hi_r;
	reg [7:0] dlr_r;
	reg [7:0] idr_r;
	reg [7:0] sel_r;
	reg [7:0] rx_hold_r;
	reg [7:0] tx_data_r;
	reg [5:0] lin_samples_r;
	reg tuned_r;

	wire enabled = ctl_r[`LUC_CTL_ENABLE];
	wire uart_mode = ctl_r[`LUC_CTL_CMD_GRP];
	wire [1:0] cmd_lo = ctl_r[1:0];
	wire [1:0] conf = ctl_r[5:4];
	wire rx_on = enabled && uart_mode && cmd_lo[1];
	wire tx_on = enabled && uart_mode && cmd_lo[0];
	wire listen = conf == `LUC_CONF_LISTEN;
	wire parity_on = uart_mode && (conf == `LUC_CONF_EVEN || conf == `LUC_CONF_ODD);
	wire parity_odd = conf == `LUC_CONF_ODD;
	wire [11:0] divisor = {div_hi_r[3:0], div_lo_r};
	wire [5:0] samples = (!uart_mode && tuned_r) ? lin_samples_r : btr_r[5:0];

	// ****************************************
	// Bus decode
	// ****************************************
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr = req && wb_we_i && wb_sel_i[0];
	wire rd = req && !wb_we_i;
	wire busy;
	wire lin_lock = busy && !uart_mode;
	wire wr_ctl = wr && wb_adr_i == `LUC_OFS_CONTROL;
	wire wr_data = wr && wb_adr_i == `LUC_OFS_DATA;
	wire rd_data = rd && wb_adr_i == `LUC_OFS_DATA;
	wire [7:0] wd = wb_dat_i[7:0];
	wire soft_rst = wr_ctl && wd[`LUC_CTL_SWRES];
	// A new command other than abort, disable, group change or soft reset while busy.
	wire bad_cmd = wr_ctl && busy && wd[`LUC_CTL_ENABLE] && wd[`LUC_CTL_CMD_GRP] == uart_mode &&
		wd[1:0] != 2'h0 && wd[1:0] != cmd_lo && !wd[`LUC_CTL_SWRES];

	// ****************************************
	// Input synchroniser and sample ticks
	// ****************************************
	reg [2:0] rx_sync_r;
	wire tx_line;
	reg rx_line_r;
	always @(posedge clk_i) begin
		if (rst_i) begin
			rx_sync_r <= 3'h7;
			rx_line_r <= 1'b1;
		end else begin
			rx_sync_r <= {rx_sync_r[1:0], serial_rx_pin_i};
			if (rx_sync_r[2] == rx_sync_r[1])
				rx_line_r <= rx_sync_r[1];
		end
	end
	wire rx_in = listen ? tx_line : rx_line_r;

	wire tick;
	luc_baud u_baud (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(!enabled),
		.div_i(divisor),
		.tick_o(tick)
	);

	// ****************************************
	// Transmitter
	// ****************************************
	reg tx_busy_r;
	reg tx_bit_r;
	reg [5:0] tx_smp_r;
	reg [3:0] tx_idx_r;
	reg [10:0] tx_frame_r;
	wire [3:0] tx_last = parity_on ? 4'ha : 4'h9;
	assign tx_line = tx_busy_r ? tx_bit_r : 1'b1;
	assign busy = tx_busy_r;
	wire tx_done = tx_busy_r && tick && tx_smp_r == samples - 6'h01 && tx_idx_r == tx_last;

	always @(posedge clk_i) begin
		if (rst_i || soft_rst || !enabled || !uart_mode) begin
			tx_busy_r <= 1'b0;
			tx_bit_r <= 1'b1;
			tx_smp_r <= 6'h00;
			tx_idx_r <= 4'h0;
			tx_frame_r <= 11'h7ff;
		end else if (!tx_busy_r) begin
			if (wr_data && tx_on) begin
				tx_busy_r <= 1'b1;
				tx_frame_r <= parity_on ? {1'b1, ^wd ^ parity_odd, wd, 1'b0} : {2'h3, wd, 1'b0};
				tx_bit_r <= 1'b0;
				tx_smp_r <= 6'h00;
				tx_idx_r <= 4'h0;
			end
		end else if (tick) begin
			if (tx_smp_r == samples - 6'h01) begin
				tx_smp_r <= 6'h00;
				if (tx_idx_r == tx_last) begin
					tx_busy_r <= 1'b0;
					tx_bit_r <= 1'b1;
				end else begin
					tx_idx_r <= tx_idx_r + 4'h1;
					tx_bit_r <= tx_frame_r[tx_idx_r + 4'h1];
				end
			end else
				tx_smp_r <= tx_smp_r + 6'h01;
		end
	end

	// ****************************************
	// Receiver with three-sample majority vote
	// ****************************************
	reg rx_act_r;
	reg [5:0] rx_smp_r;
	reg [3:0] rx_idx_r;
	reg [9:0] rx_shift_r;
	reg [2:0] vote_r;
	reg rx_prev_r;
	wire [5:0] mid = {1'b0, samples[5:1]};
	wire voted = (vote_r[0] & vote_r[1]) | (vote_r[1] & vote_r[2]) | (vote_r[0] & vote_r[2]);
	wire rx_bit_end = rx_act_r && tick && rx_smp_r == mid + 6'h03;
	wire rx_done = rx_bit_end && rx_idx_r == tx_last;
	always @(posedge clk_i) begin
		if (rst_i || soft_rst || !rx_on) begin
			rx_act_r <= 1'b0;
			rx_smp_r <= 6'h00;
			rx_idx_r <= 4'h0;
			rx_shift_r <= 10'h000;
			vote_r <= 3'h7;
			rx_prev_r <= 1'b1;
		end else if (tick) begin
			rx_prev_r <= rx_in;
			if (!rx_act_r) begin
				if (rx_prev_r && !rx_in) begin
					rx_act_r <= 1'b1;
					rx_smp_r <= 6'h01;
					rx_idx_r <= 4'h0;
				end
			end else begin
				if (rx_smp_r >= mid && rx_smp_r <= mid + 6'h02)
					vote_r <= {vote_r[1:0], rx_in};
				if (rx_done || (rx_bit_end && rx_idx_r == 4'h0 && voted))
					rx_act_r <= 1'b0;
				if (rx_bit_end && rx_idx_r != 4'h0 && rx_idx_r != tx_last)
					rx_shift_r <= {voted, rx_shift_r[9:1]};
				if (rx_bit_end)
					rx_idx_r <= rx_idx_r + 4'h1;
				rx_smp_r <= (rx_smp_r == samples - 6'h01) ? 6'h00 : rx_smp_r + 6'h01;
			end
		end
	end
	// With parity the parity bit lands on top, so the data sit one place lower.
	wire [7:0] rx_byte = parity_on ? rx_shift_r[8:1] : rx_shift_r[9:2];

	// ****************************************
	// LIN slave header resynchronisation
	// ****************************************
	reg [11:0] low_cnt_r;
	reg [2:0] sync_edges_r;
	reg [11:0] sync_cnt_r;
	reg sync_run_r;
	reg lin_in_prev_r;
	wire lin_slave = enabled && !uart_mode && !idr_r[`LUC_MASTER_BIT];
	wire [11:0] break_min = {7'h00, `LUC_BREAK_MIN_BITS} << 5;
	wire [11:0] break_max = {7'h00, `LUC_BREAK_MAX_BITS} << 5;
	always @(posedge clk_i) begin
		if (tuned_r && wr_ctl && wd[1:0] == 2'h0 && cmd_lo != 2'h0)
			tuned_r <= 1'b0;
		if (rst_i || soft_rst || !lin_slave) begin
			low_cnt_r <= 12'h000;
			sync_edges_r <= 3'h0;
			sync_cnt_r <= 12'h000;
			sync_run_r <= 1'b0;
			lin_in_prev_r <= 1'b1;
			lin_samples_r <= `LUC_SAMPLES_DEFAULT;
			tuned_r <= 1'b0;
		end else if (tick) begin
			lin_in_prev_r <= rx_in;
			if (!rx_in && low_cnt_r != 12'hfff)
				low_cnt_r <= low_cnt_r + 12'h001;
			// Break length is measured at the default count of samples.
			if (rx_in && !lin_in_prev_r) begin
				low_cnt_r <= 12'h000;
				if (!tuned_r && low_cnt_r >= break_min && low_cnt_r <= break_max) begin
					sync_run_r <= 1'b1;
					sync_edges_r <= 3'h0;
					sync_cnt_r <= 12'h000;
				end
			end
			if (sync_run_r) begin
				sync_cnt_r <= sync_cnt_r + 12'h001;
				if (!rx_in && lin_in_prev_r) begin
					if (sync_edges_r == `LUC_SYNC_EDGES) begin
						// Eight bit times between first and fifth falling edge.
						sync_run_r <= 1'b0;
						lin_samples_r <= sync_cnt_r[8:3];
						tuned_r <= 1'b1;
					end
					if (sync_edges_r == 3'h0)
						sync_cnt_r <= 12'h000;
					sync_edges_r <= sync_edges_r + 3'h1;
				end
			end
		end
	end

	// ****************************************
	// Register writes and flags
	// ****************************************
	wire err_clr = wr && wb_adr_i == `LUC_OFS_STATUS && wd[`LUC_ST_ERR];
	always @(posedge clk_i) begin
		if (rst_i || soft_rst) begin
			ctl_r <= `LUC_RST_CONTROL;
			irq_en_r <= {irq_en_r[7:4] & {4{!rst_i}}, 4'h0};
			btr_r <= `LUC_RST_BIT_SAMPLING;
			if (rst_i) begin
				div_lo_r <= 8'h00;
				div_hi_r <= 8'h00;
			end
			dlr_r <= 8'h00;
			idr_r <= `LUC_RST_IDENT;
			sel_r <= {sel_r[7:4] & {4{!rst_i}}, 4'h0};
			err_r <= 8'h00;
			rxok_r <= 1'b0;
			txok_r <= 1'b0;
			rx_hold_r <= 8'h00;
			tx_data_r <= 8'h00;
		end else begin
			if (wr_ctl) begin
				if (bad_cmd)
					ctl_r <= (ctl_r & `LUC_CTL_BUSY_MASK) | (ctl_r & ~`LUC_CTL_BUSY_MASK);
				else if (busy)
					ctl_r <= (wd & `LUC_CTL_BUSY_MASK) | (ctl_r & ~`LUC_CTL_BUSY_MASK);
				else
					ctl_r <= wd & 8'h7f;
			end
			if (wr && wb_adr_i == `LUC_OFS_IRQ_EN)
				irq_en_r <= wd & 8'h0f;
			if (wr && wb_adr_i == `LUC_OFS_BIT_SAMPLING)
				btr_r <= wd;
			if (wr && !lin_lock && wb_adr_i == `LUC_OFS_DIV_LOW)
				div_lo_r <= wd;
			if (wr && !lin_lock && wb_adr_i == `LUC_OFS_DIV_HIGH)
				div_hi_r <= {4'h0, wd[3:0]};
			if (wr && !lin_lock && !uart_mode && wb_adr_i == `LUC_OFS_LENGTHS)
				dlr_r <= wd;
			else if (uart_mode)
				dlr_r <= 8'h00;
			if (wr && !lin_lock && wb_adr_i == `LUC_OFS_IDENT)
				idr_r <= wd;
			if (wr && wb_adr_i == `LUC_OFS_BUF_SEL)
				sel_r <= wd;
			if (wr_data && !busy)
				tx_data_r <= wd;
			// Set beats clear for every hardware flag: the sets come after the clear.
			if (err_clr)
				err_r <= 8'h00;
			if (rx_done && !voted)
				err_r[`LUC_ER_FRAME] <= 1'b1;
			if ((rx_done && rxok_r) || bad_cmd)
				err_r[`LUC_ER_OVERRUN] <= 1'b1;
			if (rx_done) begin
				rx_hold_r <= rx_byte;
				rxok_r <= 1'b1;
			end else if (rd_data || (wr && wb_adr_i == `LUC_OFS_STATUS && wd[`LUC_ST_RXOK]))
				rxok_r <= 1'b0;
			if (tx_done)
				txok_r <= 1'b1;
			else if ((wr_data && tx_on && !busy) ||
				(wr && wb_adr_i == `LUC_OFS_STATUS && wd[`LUC_ST_TXOK]))
				txok_r <= 1'b0;
		end
	end

	// ****************************************
	// Read mux, acknowledge and pins
	// ****************************************
	reg [7:0] rdat;
	always @* begin
		case (wb_adr_i)
			`LUC_OFS_CONTROL: rdat = ctl_r;
			`LUC_OFS_STATUS: rdat = {3'h0, busy, |err_r, 1'b0, txok_r, rxok_r};
			`LUC_OFS_IRQ_EN: rdat = irq_en_r;
			`LUC_OFS_ERRORS: rdat = err_r;
			`LUC_OFS_BIT_SAMPLING: rdat = {btr_r[7:6], samples};
			`LUC_OFS_DIV_LOW: rdat = div_lo_r;
			`LUC_OFS_DIV_HIGH: rdat = div_hi_r;
			`LUC_OFS_LENGTHS: rdat = dlr_r;
			`LUC_OFS_IDENT: rdat = idr_r;
			`LUC_OFS_BUF_SEL: rdat = sel_r;
			`LUC_OFS_DATA: rdat = uart_mode ? rx_hold_r : tx_data_r;
			default: rdat = 8'h00;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			serial_tx_pin_o <= 1'b1;
			serial_tx_oe_n_o <= 1'b1;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= rd ? {24'h000000, rdat} : 32'h00000000;
			serial_tx_pin_o <= listen ? 1'b1 : tx_line;
			serial_tx_oe_n_o <= !(enabled && !listen);
		end
	end
endmodule

// ===== verif/luc_peer.sv
// Serial peer model: sends frames into the receiver and captures bytes sent by the block.
// Assumes 8 data bits, LSB first, no parity, one stop bit and BIT_CLKS clocks per bit.
`timescale 1ns/10ps
module luc_peer #(parameter int BIT_CLKS = 32) (
	// Clock
	input wire logic clk_i,
	// Serial lines
	output logic rx_o,
	input wire logic tx_i,
	input wire logic oe_n_i
);
	logic [7:0] got = 8'h00;
	logic [7:0] sh = 8'h00;
	int n_got = 0;
	initial rx_o = 1'b1;
	// A stop value of 0 sends a dominant stop bit.
	task send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_o <= f[i];
			repeat (BIT_CLKS) @(posedge clk_i);
		end
		rx_o <= 1'b1;
		@(posedge clk_i);
	endtask
	// Frames are only taken while the block drives the pin.
	always begin
		@(negedge tx_i);
		if (oe_n_i === 1'b0) begin
			repeat (BIT_CLKS / 2) @(posedge clk_i);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CLKS) @(posedge clk_i);
				sh[i] = tx_i;
			end
			repeat (BIT_CLKS) @(posedge clk_i);
			if (tx_i === 1'b1) begin
				got = sh;
				n_got++;
			end
		end
	end
endmodule

// ===== verif/luc_top_props.sv
// Checker for the controller: bus handshake, transmit pin idle and enable behaviour.
// Assumes the default bit timing of 32 clocks per bit while the block transmits.
`timescale 1ns/10ps
`include "luc_consts.vh"
module luc_top_props (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// Serial
	input wire serial_rx_pin_i,
	input wire serial_tx_pin_o,
	input wire serial_tx_oe_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire ctl = take && wb_we_i && wb_sel_i[0] && wb_adr_i == `LUC_OFS_CONTROL;
	sequence s_ctl_off;
		ctl && !wb_dat_i[3];
	endsequence
	sequence s_ctl_drive;
		ctl && wb_dat_i[3] && !wb_dat_i[7] && wb_dat_i[5:4] != 2'h3;
	endsequence
	sequence s_ctl_listen;
		ctl && wb_dat_i[3] && !wb_dat_i[7] && wb_dat_i[5:4] == 2'h3;
	endsequence
	property p_ack_resp;
		disable iff (rst_i) take |=> wb_ack_o;
	endproperty
	property p_ack_pulse;
		disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_ack_cause;
		disable iff (rst_i) !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	property p_unmapped;
		disable iff (rst_i) take && !wb_we_i && wb_adr_i > 6'h28 |=> wb_dat_o == 32'h0;
	endproperty
	property p_rst_idle;
		rst_i |=> serial_tx_pin_o && serial_tx_oe_n_o;
	endproperty
	property p_bit_len;
		disable iff (rst_i) $fell(serial_tx_pin_o) && !serial_tx_oe_n_o
			|-> ##31 (!serial_tx_pin_o || serial_tx_oe_n_o);
	endproperty
	property p_off;
		disable iff (rst_i) s_ctl_off |-> ##[1:3] serial_tx_oe_n_o && serial_tx_pin_o;
	endproperty
	property p_drive;
		disable iff (rst_i) s_ctl_drive |-> ##[1:3] !serial_tx_oe_n_o;
	endproperty
	property p_listen;
		disable iff (rst_i) s_ctl_listen |-> ##[1:3] serial_tx_oe_n_o;
	endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_rst_idle: assert property (p_rst_idle) else $error("tx not idle in reset");
	a_bit_len: assert property (p_bit_len) else $error("bit too short");
	a_off: assert property (p_off) else $error("disable not immediate");
	a_drive: assert property (p_drive) else $error("tx pin not driven");
	a_listen: assert property (p_listen) else $error("tx pin driven in listen");
endmodule
bind luc_top luc_top_props luc_top_props_inst (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.serial_rx_pin_i(serial_rx_pin_i), .serial_tx_pin_o(serial_tx_pin_o),
	.serial_tx_oe_n_o(serial_tx_oe_n_o));

// ===== verif/tb.sv
// Testbench: register tests over Wishbone with a serial peer on the pins.
// Assumes default bit timing, so one bit lasts 32 clocks.
`timescale 1ns/10ps
`include "luc_consts.vh"
module tb;
	localparam logic [5:0] a_ctl = `LUC_OFS_CONTROL;
	localparam logic [5:0] a_st = `LUC_OFS_STATUS;
	localparam logic [5:0] a_er = `LUC_OFS_ERRORS;
	localparam logic [5:0] a_dat = `LUC_OFS_DATA;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rxl;
	logic [5:0] adr = 0;
	logic [31:0] dw = 0;
	logic [7:0] v;
	logic [7:0] rv [11] = '{0, 0, 0, 0, 8'h20, 0, 0, 0, 8'h80, 0, 0};
	wire [31:0] dr;
	wire ack, tx, oe_n;
	int n_fail = 0, samples_checked = 0;
	luc_top luc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr),
		.wb_ack_o(ack), .serial_rx_pin_i(rxl), .serial_tx_pin_o(tx),
		.serial_tx_oe_n_o(oe_n));
	luc_peer peer_inst (.clk_i(clk_i), .rx_o(rxl), .tx_i(tx), .oe_n_i(oe_n));
	initial forever #2.5 clk_i = ~clk_i;
	task test_done;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [7:0] seen, exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// The request is held until ack is sampled high, then released.
	task xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
		int i;
		i = 0;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dw <= {24'h0, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && i < 50) begin
			@(posedge clk_i);
			i++;
		end
		chk({7'h0, ack}, 8'h01, "bus ack");
		v = dr[7:0];
		cyc <= 0;
		stb <= 0;
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		xfer(1, a, d);
	endtask
	task rd(input logic [5:0] a);
		xfer(0, a, 8'h00);
	endtask
	task pol(input logic [5:0] a, input logic [7:0] m, e, input string w);
		int i;
		i = 0;
		rd(a);
		while ((v & m) !== e && i < 300) begin
			rd(a);
			i++;
		end
		chk(v & m, e, w);
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		$display("watchdog expired");
		test_done;
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		for (int i = 0; i < 11; i++) begin
			rd(6'(i * 4));
			chk(v, rv[i], "reset value");
		end
		rd(6'h2c);
		chk(v, 8'h00, "unmapped");
		$display("test reset done");
		wr(a_ctl, 8'h0f);
		wr(a_dat, 8'ha5);
		pol(a_st, 8'h12, 8'h10, "busy tx");
		wr(a_ctl, 8'h4f);
		rd(a_ctl);
		chk(v, 8'h0f, "ctl locked");
		pol(a_st, 8'h12, 8'h02, "tx done");
		chk(peer_inst.got, 8'ha5, "tx byte");
		wr(a_ctl, 8'h4f);
		rd(a_ctl);
		chk(v, 8'h4f, "ctl free");
		$display("test transmit done");
		peer_inst.send(8'h3c, 1);
		rd(a_st);
		chk(v & 8'h10, 8'h00, "no rx busy");
		pol(a_st, 8'h01, 8'h01, "rx flag");
		rd(a_dat);
		chk(v, 8'h3c, "rx byte");
		rd(a_st);
		chk(v & 8'h01, 8'h00, "rx flag read");
		peer_inst.send(8'h11, 1);
		peer_inst.send(8'h22, 1);
		peer_inst.send(8'h33, 1);
		pol(a_er, 8'h40, 8'h40, "overrun");
		rd(a_dat);
		chk(v, 8'h33, "overwrite");
		peer_inst.send(8'h44, 0);
		pol(a_er, 8'h10, 8'h10, "framing");
		wr(a_st, 8'h01);
		rd(a_st);
		chk(v & 8'h01, 8'h00, "rx flag clear");
		wr(a_st, 8'h08);
		rd(a_er);
		chk(v, 8'h00, "errors clear");
		$display("test receive done");
		wr(a_ctl, 8'h3f);
		@(posedge clk_i);
		chk({7'h0, oe_n}, 8'h01, "listen pin off");
		wr(a_dat, 8'h5a);
		pol(a_st, 8'h01, 8'h01, "loop rx");
		rd(a_dat);
		chk(v, 8'h5a, "loop byte");
		chk(8'(peer_inst.n_got), 8'h01, "pin quiet");
		$display("test listen done");
		wr(`LUC_OFS_DIV_LOW, 8'h12);
		wr(`LUC_OFS_DIV_HIGH, 8'h03);
		wr(`LUC_OFS_IRQ_EN, 8'hff);
		wr(`LUC_OFS_BUF_SEL, 8'hff);
		wr(a_ctl, 8'h80);
		rd(`LUC_OFS_DIV_LOW);
		chk(v, 8'h12, "div low kept");
		rd(`LUC_OFS_DIV_HIGH);
		chk(v & 8'h0f, 8'h03, "div high kept");
		rd(`LUC_OFS_IRQ_EN);
		chk(v & 8'h0f, 8'h00, "irq low clear");
		rd(`LUC_OFS_BUF_SEL);
		chk(v & 8'h0f, 8'h00, "sel low clear");
		rd(a_ctl);
		chk(v, 8'h00, "ctl soft reset");
		rd(`LUC_OFS_IDENT);
		chk(v, 8'h80, "ident soft reset");
		chk({7'h0, tx}, 8'h01, "tx idle");
		$display("test soft reset done");
		test_done;
	end
endmodule
